// ---- hdl/irs_pkg.sv ----
package irs_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned LINK_BAUD    = 9600;
  localparam int unsigned BIT_CYCLES   = (CLK_HZ + LINK_BAUD - 1) / LINK_BAUD;
  localparam int unsigned SILENCE_S    = 10;
  localparam int unsigned SILENCE_BITS = SILENCE_S * LINK_BAUD;

  // ==========================================================
  // buffers
  localparam int unsigned HOST_BUF_DEPTH = 29;
  localparam int unsigned HOST_CTS_LEVEL = 23;
  localparam int unsigned IR_BLOCK_BYTES = 64;

  // ==========================================================
  // decoded frames from the primary
  localparam logic [3:0] F_XID     = 4'h1;  // numbered discovery packet
  localparam logic [3:0] F_XID_END = 4'h2;  // unnumbered identification packet
  localparam logic [3:0] F_PARAM   = 4'h3;  // parameter proposal
  localparam logic [3:0] F_IAS     = 4'h4;  // information query, slot = query index
  localparam logic [3:0] F_POLL    = 4'h5;  // supervisory poll
  localparam logic [3:0] F_DATA    = 4'h6;  // information frame
  localparam logic [3:0] F_CLOSE   = 4'h7;  // close link

  // ==========================================================
  // responses to the primary
  localparam logic [3:0] R_XID      = 4'h1;
  localparam logic [3:0] R_PARAM    = 4'h2;
  localparam logic [3:0] R_IAS_NAME = 4'h3;
  localparam logic [3:0] R_IAS_ADDR = 4'h4;
  localparam logic [3:0] R_IAS_CAPS = 4'h5;
  localparam logic [3:0] R_READY    = 4'h6;
  localparam logic [3:0] R_DATA     = 4'h7;
  localparam logic [3:0] R_REJECT   = 4'h8;
  localparam logic [3:0] R_CLOSE_OK = 4'h9;

  localparam logic [2:0] IAS_Q_NAME = 3'h0;
  localparam logic [2:0] IAS_Q_ADDR = 3'h1;

  // parameter values; all but TURN_PARAM are carried in responses
  localparam logic [7:0] RATE_9600       = 8'h02;
  localparam logic [7:0] TURN_PARAM      = 8'h01;
  localparam logic [7:0] SERVICE_NAME    = 8'h5a;  // arbitrary value
  localparam logic [7:0] SERVICE_ADDR    = 8'h01;
  localparam logic [7:0] IAS_CLASS_MODEM = 8'h01;

  // ==========================================================
  // states
  typedef enum logic [2:0] {
    L_DISC      = 3'b001,
    L_DISCOVERY = 3'b010,
    L_CONN      = 3'b100
  } irs_link_e;

  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_TURN = 3'b010,
    T_DATA = 3'b100
  } irs_tx_e;
endpackage

// ---- hdl/irs_byte_buf.sv ----
`timescale 1ns/1ps
`default_nettype none
module irs_byte_buf #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 29,
  parameter int unsigned AW    = 5
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // write port
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // read port, data one cycle after address
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule
`default_nettype wire

// ---- hdl/irs_link_fsm.sv ----
`timescale 1ns/1ps
`default_nettype none
module irs_link_fsm #(
  parameter int unsigned BIT_CYCLES   = irs_pkg::BIT_CYCLES,
  parameter int unsigned SILENCE_BITS = irs_pkg::SILENCE_BITS
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // decoded frames from the primary
  input  wire logic       frameValid,
  input  wire logic [3:0] frameKind,
  input  wire logic [2:0] frameSlot,
  input  wire logic       frameGood,
  input  wire logic       frameAck,
  input  wire logic       irByteValid,
  input  wire logic [7:0] irByte,
  // responses to the primary
  input  wire logic       irTxReady,
  output logic            respValid,
  output logic      [3:0] respKind,
  output logic      [7:0] respParam,
  output logic            respByteValid,
  output logic      [7:0] respByte,
  output logic            respLast,
  // host uart side
  input  wire logic       hostRxValid,
  input  wire logic [7:0] hostRxData,
  output logic            cts,
  output logic            hostTxValid,
  output logic      [7:0] hostTxData,
  // status
  output logic      [2:0] linkPhase,
  output logic      [7:0] linkRate
);
  // ==========================================================
  // bit-time divider, restarted by every frame
  logic [15:0] divCnt, next_divCnt;
  logic        tick, next_tick;

  always_comb begin
    next_tick   = 1'b0;
    next_divCnt = divCnt + 16'h0001;
    if (frameValid || divCnt == 16'(BIT_CYCLES - 1)) begin
      next_divCnt = '0;
      next_tick   = !frameValid;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      divCnt <= '0;
      tick   <= 1'b0;
    end else begin
      divCnt <= next_divCnt;
      tick   <= next_tick;
    end
  end

  // ==========================================================
  // link state
  irs_pkg::irs_link_e linkState, next_linkState;
  irs_pkg::irs_tx_e   txState, next_txState;
  logic        xidSent, next_xidSent;
  logic        pending, next_pending;
  logic [4:0]  wrCount, next_wrCount;
  logic [31:0] silence, next_silence;
  logic [6:0]  irCount, next_irCount;
  logic        next_cts, next_hostTxValid;
  logic [7:0]  next_hostTxData;
  logic        reqValid, bufWr;
  logic [3:0]  reqKind;
  logic [7:0]  reqParam;
  logic [4:0]  liveCount;

  always_comb begin
    next_linkState   = linkState;
    next_xidSent     = xidSent;
    next_pending     = pending;
    next_wrCount     = wrCount;
    next_silence     = silence;
    next_irCount     = irCount;
    next_hostTxValid = 1'b0;
    next_hostTxData  = hostTxData;
    reqValid         = 1'b0;
    reqKind          = irs_pkg::R_READY;
    reqParam         = '0;
    liveCount        = (frameAck && pending) ? 5'h00 : wrCount;
    bufWr            = 1'b0;
    if (tick && linkState != irs_pkg::L_DISC) begin
      next_silence = silence + 32'h1;
    end
    if (frameValid) begin
      next_silence = '0;
      next_irCount = '0;
    end
    unique case (linkState)
      irs_pkg::L_DISC: begin
        next_pending = 1'b0;
        next_wrCount = '0;
        if (frameValid && frameKind == irs_pkg::F_XID) begin
          if (frameSlot == 3'h0) begin
            reqValid     = 1'b1;
            reqKind      = irs_pkg::R_XID;
            reqParam     = irs_pkg::RATE_9600;
            next_xidSent = 1'b1;
          end
        end else if (frameValid && frameKind == irs_pkg::F_XID_END) begin
          if (xidSent) begin
            next_linkState = irs_pkg::L_DISCOVERY;
          end
          next_xidSent = 1'b0;
        end
      end
      irs_pkg::L_DISCOVERY: begin
        if (frameValid) begin
          unique case (frameKind)
            irs_pkg::F_PARAM: begin
              reqValid = 1'b1;
              reqKind  = irs_pkg::R_PARAM;
              reqParam = irs_pkg::RATE_9600;
            end
            irs_pkg::F_IAS: begin
              reqValid = 1'b1;
              if (frameSlot == irs_pkg::IAS_Q_NAME) begin
                reqKind  = irs_pkg::R_IAS_NAME;
                reqParam = irs_pkg::SERVICE_NAME;
              end else if (frameSlot == irs_pkg::IAS_Q_ADDR) begin
                reqKind  = irs_pkg::R_IAS_ADDR;
                reqParam = irs_pkg::SERVICE_ADDR;
              end else begin
                reqKind  = irs_pkg::R_IAS_CAPS;
                reqParam = irs_pkg::IAS_CLASS_MODEM;
              end
            end
            irs_pkg::F_POLL: begin
              reqValid       = 1'b1;
              next_linkState = irs_pkg::L_CONN;
            end
            irs_pkg::F_CLOSE: begin
              reqValid       = 1'b1;
              reqKind        = irs_pkg::R_CLOSE_OK;
              next_linkState = irs_pkg::L_DISC;
            end
            default: begin
            end
          endcase
        end
      end
      irs_pkg::L_CONN: begin
        // host bytes are taken only while no block awaits acknowledgement
        if (hostRxValid && !pending && wrCount < 5'(irs_pkg::HOST_BUF_DEPTH)) begin
          bufWr        = 1'b1;
          next_wrCount = wrCount + 5'h01;
        end
        if (irByteValid && irCount < 7'(irs_pkg::IR_BLOCK_BYTES)) begin
          next_irCount     = irCount + 7'h01;
          next_hostTxValid = 1'b1;
          next_hostTxData  = irByte;
        end
        if (frameValid) begin
          reqValid = 1'b1;
          if (frameKind == irs_pkg::F_CLOSE) begin
            reqKind        = irs_pkg::R_CLOSE_OK;
            next_linkState = irs_pkg::L_DISC;
          end else if (frameKind == irs_pkg::F_DATA && !frameGood) begin
            reqKind = irs_pkg::R_REJECT;
          end else begin
            if (frameAck && pending) begin
              next_pending = 1'b0;
              next_wrCount = bufWr ? 5'h01 : 5'h00;
            end
            if (liveCount != 5'h00) begin
              reqKind      = irs_pkg::R_DATA;
              next_pending = 1'b1;
            end
          end
        end
      end
    endcase
    if (linkState != irs_pkg::L_DISC && silence >= SILENCE_BITS) begin
      next_linkState = irs_pkg::L_DISC;
    end
    next_cts = !(next_linkState == irs_pkg::L_CONN && !next_pending
                 && next_wrCount < 5'(irs_pkg::HOST_CTS_LEVEL));
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      linkState   <= irs_pkg::L_DISC;
      xidSent     <= 1'b0;
      pending     <= 1'b0;
      wrCount     <= '0;
      silence     <= '0;
      irCount     <= '0;
      cts         <= 1'b1;
      hostTxValid <= 1'b0;
      hostTxData  <= '0;
    end else begin
      linkState   <= next_linkState;
      xidSent     <= next_xidSent;
      pending     <= next_pending;
      wrCount     <= next_wrCount;
      silence     <= next_silence;
      irCount     <= next_irCount;
      cts         <= next_cts;
      hostTxValid <= next_hostTxValid;
      hostTxData  <= next_hostTxData;
    end
  end

  assign linkPhase = linkState;
  assign linkRate  = irs_pkg::RATE_9600;

  // ==========================================================
  // response sender
  logic [4:0] rdIdx, next_rdIdx;
  logic [7:0] rdData;
  logic [3:0] txKind, next_txKind;
  logic [7:0] txParam, next_txParam;
  logic       next_respValid, next_respByteValid, next_respLast;
  logic [7:0] next_respByte;

  always_comb begin
    next_txState       = txState;
    next_txKind        = txKind;
    next_txParam       = txParam;
    next_rdIdx         = rdIdx;
    next_respValid     = 1'b0;
    next_respByteValid = 1'b0;
    next_respLast      = 1'b0;
    next_respByte      = respByte;
    unique case (txState)
      irs_pkg::T_IDLE: begin
        if (reqValid) begin
          next_txState = irs_pkg::T_TURN;
          next_txKind  = reqKind;
          next_txParam = reqParam;
        end
      end
      irs_pkg::T_TURN: begin
        // a frame ending restarts the divider, so this waits a full bit
        if (tick) begin
          next_respValid = 1'b1;
          next_rdIdx     = '0;
          next_txState   = (txKind == irs_pkg::R_DATA) ? irs_pkg::T_DATA : irs_pkg::T_IDLE;
        end
      end
      irs_pkg::T_DATA: begin
        if (irTxReady && !respByteValid && !respValid) begin
          next_respByteValid = 1'b1;
          next_respByte      = rdData;
          next_rdIdx         = rdIdx + 5'h01;
          if (rdIdx == wrCount - 5'h01) begin
            next_respLast = 1'b1;
            next_txState  = irs_pkg::T_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txState       <= irs_pkg::T_IDLE;
      txKind        <= '0;
      txParam       <= '0;
      rdIdx         <= '0;
      respValid     <= 1'b0;
      respByteValid <= 1'b0;
      respLast      <= 1'b0;
      respByte      <= '0;
    end else begin
      txState       <= next_txState;
      txKind        <= next_txKind;
      txParam       <= next_txParam;
      rdIdx         <= next_rdIdx;
      respValid     <= next_respValid;
      respByteValid <= next_respByteValid;
      respLast      <= next_respLast;
      respByte      <= next_respByte;
    end
  end

  assign respKind  = txKind;
  assign respParam = txParam;

  irs_byte_buf #(
    .WIDTH (8),
    .DEPTH (irs_pkg::HOST_BUF_DEPTH),
    .AW    (5)
  ) hostBuf (
    .mclk   (mclk),
    .resetn (resetn),
    .wrEn   (bufWr),
    .wrAddr (wrCount),
    .wrData (hostRxData),
    .rdAddr (next_rdIdx),
    .rdData (rdData)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_cts_before_conn: assert property (linkState != irs_pkg::L_CONN |-> cts)
    else $error("cts low outside connected phase");
  a_cts_level_hold: assert property (wrCount >= 5'(irs_pkg::HOST_CTS_LEVEL) |-> cts)
    else $error("cts low at blocking level");
  a_buf_bound: assert property (wrCount <= 5'(irs_pkg::HOST_BUF_DEPTH))
    else $error("host buffer overfilled");
  a_slot_zero_answer: assert property (frameValid && frameKind == irs_pkg::F_XID
      && frameSlot == 3'h0 && linkState == irs_pkg::L_DISC && txState == irs_pkg::T_IDLE
      |=> txState == irs_pkg::T_TURN && txKind == irs_pkg::R_XID)
    else $error("slot zero not answered");
  a_turn_gap: assert property ($rose(respValid)
      |-> $past(tick) && $past(txState) == irs_pkg::T_TURN)
    else $error("response without turnaround");
  a_rate_only: assert property (respValid && respKind == irs_pkg::R_PARAM
      |-> respParam == irs_pkg::RATE_9600)
    else $error("rate other than 9600 offered");
  a_modem_class: assert property (respValid && respKind == irs_pkg::R_IAS_CAPS
      |-> respParam == irs_pkg::IAS_CLASS_MODEM)
    else $error("capability not modem class");
  a_close_ack: assert property (frameValid && frameKind == irs_pkg::F_CLOSE
      && linkState == irs_pkg::L_CONN && txState == irs_pkg::T_IDLE
      |=> linkState == irs_pkg::L_DISC && txKind == irs_pkg::R_CLOSE_OK ##1 cts)
    else $error("close not confirmed");
  a_reject_bad: assert property (frameValid && frameKind == irs_pkg::F_DATA
      && !frameGood && linkState == irs_pkg::L_CONN && txState == irs_pkg::T_IDLE
      |=> txKind == irs_pkg::R_REJECT)
    else $error("bad frame not rejected");
  a_silence_drop: assert property (linkState != irs_pkg::L_DISC
      && silence >= SILENCE_BITS && !frameValid |=> linkState == irs_pkg::L_DISC)
    else $error("silence timeout missed");

  c_connected: cover property ($rose(linkState == irs_pkg::L_CONN));
  c_data_sent: cover property (respByteValid && respLast);
  c_cts_level: cover property (linkState == irs_pkg::L_CONN && $rose(cts) && !pending);
  c_closed: cover property ($past(linkState) == irs_pkg::L_CONN && linkState == irs_pkg::L_DISC);
endmodule
`default_nettype wire

// ---- tb/irs_prim_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module irs_prim_model (
  // clock and encoder stall mode
  input  wire logic       mclk,
  input  wire logic       slow,
  // decoded frame stream
  output logic            frameValid,
  output logic      [3:0] frameKind,
  output logic      [2:0] frameSlot,
  output logic            frameGood,
  output logic            frameAck,
  output logic            irByteValid,
  output logic      [7:0] irByte,
  // encoder readiness
  output logic            irTxReady
);
  logic [1:0] tick = 2'h0;

  initial begin
    frameValid  = 1'b0;
    frameKind   = 4'h0;
    frameSlot   = 3'h0;
    frameGood   = 1'b0;
    frameAck    = 1'b0;
    irByteValid = 1'b0;
    irByte      = 8'h00;
  end

  // a slow encoder takes one byte in four cycles
  always @(posedge mclk) begin
    tick      <= tick + 2'h1;
    irTxReady <= !slow || (tick == 2'h0);
  end

  // ==========================================================
  // payload bytes first, then the end-of-frame strobe
  task automatic sendFrame(input logic [3:0] kind, input logic [2:0] slot,
                           input logic good, input logic ack, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      irByteValid <= 1'b1;
      irByte      <= 8'(i + 64);
      @(posedge mclk);
      irByteValid <= 1'b0;
      irByte      <= ~8'(i + 64); // no stale byte once released
    end
    @(posedge mclk);
    frameValid <= 1'b1;
    frameKind  <= kind;
    frameSlot  <= slot;
    frameGood  <= good;
    frameAck   <= ack;
    @(posedge mclk);
    frameValid <= 1'b0;
    frameKind  <= ~kind;
    frameSlot  <= ~slot;
    frameGood  <= ~good;
    frameAck   <= ~ack;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_ir_secondary_link_state_machine.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ir_secondary_link_state_machine;
  localparam int BITC = 8;
  localparam int SILB = 20;
  localparam logic [2:0] PD = irs_pkg::L_DISC;
  localparam logic [2:0] PY = irs_pkg::L_DISCOVERY;
  localparam logic [2:0] PC = irs_pkg::L_CONN;

  typedef struct packed {
    logic [3:0] kind;
    logic [2:0] slot;
    logic       resp;
    logic [3:0] rkind;
    logic       chkP;
    logic [7:0] rparam;
    logic [2:0] phase;
    logic       ctsExp;
  } irs_row_s;

  logic       mclk        = 1'b0;
  logic       resetn      = 1'b0;
  logic       hostRxValid = 1'b0;
  logic [7:0] hostRxData  = 8'h00;
  logic       slow        = 1'b0;
  logic       frameValid, frameGood, frameAck, irByteValid, irTxReady;
  logic [3:0] frameKind, respKind;
  logic [2:0] frameSlot, linkPhase;
  logic [7:0] irByte, respParam, respByte, hostTxData, linkRate;
  logic       respValid, respByteValid, respLast, cts, hostTxValid, gotResp;
  int         failures = 0;
  int         total_checks = 0;
  int         lat, lastCnt, k;
  logic [7:0] rq[$];
  logic [7:0] hq[$];
  irs_row_s   rows [8];

  always #2.5 mclk = ~mclk;

  irs_prim_model prim (.mclk(mclk), .slow(slow), .frameValid(frameValid),
    .frameKind(frameKind), .frameSlot(frameSlot), .frameGood(frameGood),
    .frameAck(frameAck), .irByteValid(irByteValid), .irByte(irByte),
    .irTxReady(irTxReady));

  irs_link_fsm #(.BIT_CYCLES(BITC), .SILENCE_BITS(SILB)) DUT (.mclk(mclk),
    .resetn(resetn), .frameValid(frameValid), .frameKind(frameKind),
    .frameSlot(frameSlot), .frameGood(frameGood), .frameAck(frameAck),
    .irByteValid(irByteValid), .irByte(irByte), .irTxReady(irTxReady),
    .respValid(respValid), .respKind(respKind), .respParam(respParam),
    .respByteValid(respByteValid), .respByte(respByte), .respLast(respLast),
    .hostRxValid(hostRxValid), .hostRxData(hostRxData), .cts(cts),
    .hostTxValid(hostTxValid), .hostTxData(hostTxData),
    .linkPhase(linkPhase), .linkRate(linkRate));

  always @(posedge mclk) begin
    if (respByteValid === 1'b1) rq.push_back(respByte);
    if (respLast === 1'b1) lastCnt++;
    if (hostTxValid === 1'b1) hq.push_back(hostTxData);
  end

  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one frame, its answer and any data block; gap keeps frames spaced
  task automatic frame(input logic [3:0] kind, input logic [2:0] slot,
                       input logic good, input logic ack, input int n);
    rq.delete();
    lastCnt = 0;
    gotResp = 1'b0;
    lat = 0;
    prim.sendFrame(kind, slot, good, ack, n);
    for (int c = 1; c <= 40 && !gotResp; c++) begin
      @(posedge mclk);
      #1;
      if (respValid === 1'b1) begin
        gotResp = 1'b1;
        lat = c;
      end
    end
    if (gotResp && respKind === irs_pkg::R_DATA) begin
      for (int c = 0; c < 300 && lastCnt == 0; c++) begin
        @(posedge mclk);
        #1;
      end
    end
    repeat (4) @(posedge mclk);
  endtask

  // host keeps quiet while cts is high
  task automatic hostSend(input int first, input int n);
    for (int i = first; i < first + n && cts === 1'b0; i++) begin
      @(posedge mclk);
      hostRxValid <= 1'b1;
      hostRxData  <= 8'(i);
      @(posedge mclk);
      hostRxValid <= 1'b0;
      hostRxData  <= ~8'(i);
      // look at cts only once this edge's update has landed
      #1;
    end
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic expectBlock();
    chk("block size", 8'h17, 8'(rq.size()));
    for (int i = 0; i < rq.size() && i < 23; i++) chk("block byte", 8'(i), rq[i]);
    chk("last marker", 8'h01, 8'(lastCnt));
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    $display("[ERR] watchdog expected finish seen hang");
    summarize();
  end

  // ==========================================================
  // tests
  initial begin
    rows = '{
      '{irs_pkg::F_XID, 3'h1, 1'b0, 4'h0, 1'b0, 8'h00, PD, 1'b1},
      '{irs_pkg::F_XID, 3'h0, 1'b1, irs_pkg::R_XID, 1'b1, irs_pkg::RATE_9600, PD, 1'b1},
      '{irs_pkg::F_XID_END, 3'h0, 1'b0, 4'h0, 1'b0, 8'h00, PY, 1'b1},
      '{irs_pkg::F_PARAM, 3'h0, 1'b1, irs_pkg::R_PARAM, 1'b1, irs_pkg::RATE_9600, PY, 1'b1},
      '{irs_pkg::F_IAS, 3'h0, 1'b1, irs_pkg::R_IAS_NAME, 1'b1, irs_pkg::SERVICE_NAME, PY, 1'b1},
      '{irs_pkg::F_IAS, 3'h1, 1'b1, irs_pkg::R_IAS_ADDR, 1'b1, irs_pkg::SERVICE_ADDR, PY, 1'b1},
      '{irs_pkg::F_IAS, 3'h2, 1'b1, irs_pkg::R_IAS_CAPS, 1'b1, irs_pkg::IAS_CLASS_MODEM, PY, 1'b1},
      '{irs_pkg::F_POLL, 3'h0, 1'b1, irs_pkg::R_READY, 1'b0, 8'h00, PC, 1'b0}};
    repeat (12) @(posedge mclk);
    chk("reset cts", 8'h01, 8'(cts));
    chk("reset phase", 8'(PD), 8'(linkPhase));
    resetn <= 1'b1;
    foreach (rows[r]) begin
      frame(rows[r].kind, rows[r].slot, 1'b1, 1'b1, 0);
      chk("answered", 8'(rows[r].resp), 8'(gotResp));
      if (rows[r].resp) begin
        chk("answer kind", 8'(rows[r].rkind), 8'(respKind));
        chk("turnaround", 8'h01, 8'(lat >= BITC && lat <= BITC + 4));
        if (rows[r].chkP) chk("answer param", rows[r].rparam, respParam);
      end
      chk("phase", 8'(rows[r].phase), 8'(linkPhase));
      chk("cts", 8'(rows[r].ctsExp), 8'(cts));
      chk("rate", irs_pkg::RATE_9600, linkRate);
      $display("row %0d done", r);
    end
    hostSend(0, 22);
    chk("cts below level", 8'h00, 8'(cts));
    hostSend(22, 1);
    chk("cts at level", 8'h01, 8'(cts));
    slow <= 1'b1;
    frame(irs_pkg::F_POLL, 3'h0, 1'b1, 1'b0, 0);
    chk("data answer", 8'(irs_pkg::R_DATA), 8'(respKind));
    expectBlock();
    chk("cts pending", 8'h01, 8'(cts));
    frame(irs_pkg::F_POLL, 3'h0, 1'b1, 1'b0, 0);
    chk("resend", 8'(irs_pkg::R_DATA), 8'(respKind));
    expectBlock();
    frame(irs_pkg::F_POLL, 3'h0, 1'b1, 1'b1, 0);
    chk("idle answer", 8'(irs_pkg::R_READY), 8'(respKind));
    chk("cts freed", 8'h00, 8'(cts));
    hostSend(0, 3);
    frame(irs_pkg::F_POLL, 3'h0, 1'b1, 1'b0, 0);
    chk("short block", 8'h03, 8'(rq.size()));
    chk("cts while pending", 8'h01, 8'(cts));
    frame(irs_pkg::F_POLL, 3'h0, 1'b1, 1'b1, 0);
    chk("cts short freed", 8'h00, 8'(cts));
    $display("host block test done");
    hq.delete();
    frame(irs_pkg::F_DATA, 3'h0, 1'b1, 1'b1, 66);
    chk("ir bytes kept", 8'h40, 8'(hq.size()));
    if (hq.size() == 64) chk("ir last byte", 8'h7f, hq[63]);
    chk("good data", 8'(irs_pkg::R_READY), 8'(respKind));
    frame(irs_pkg::F_DATA, 3'h0, 1'b0, 1'b1, 2);
    chk("bad data", 8'(irs_pkg::R_REJECT), 8'(respKind));
    frame(irs_pkg::F_CLOSE, 3'h0, 1'b1, 1'b1, 0);
    chk("close answer", 8'(irs_pkg::R_CLOSE_OK), 8'(respKind));
    chk("close phase", 8'(PD), 8'(linkPhase));
    chk("close cts", 8'h01, 8'(cts));
    $display("ir data and close test done");
    repeat (2) begin
      frame(irs_pkg::F_XID, 3'h0, 1'b1, 1'b1, 0);
      chk("sweep answer", 8'h01, 8'(gotResp));
    end
    frame(irs_pkg::F_XID_END, 3'h0, 1'b1, 1'b1, 0);
    frame(irs_pkg::F_POLL, 3'h0, 1'b1, 1'b1, 0);
    chk("reconnect", 8'(PC), 8'(linkPhase));
    for (k = 0; k < 250 && linkPhase !== PD; k++) begin
      @(posedge mclk);
      #1;
    end
    chk("silence span", 8'h01, 8'(k >= 100 && k <= 180));
    $display("silence test done");
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    #1;
    chk("mid reset cts", 8'h01, 8'(cts));
    chk("mid reset phase", 8'(PD), 8'(linkPhase));
    chk("mid reset kind", 8'h00, 8'(respKind));
    @(posedge mclk);
    resetn <= 1'b1;
    frame(irs_pkg::F_XID, 3'h0, 1'b1, 1'b1, 0);
    chk("after reset", 8'(irs_pkg::R_XID), 8'(respKind));
    $display("reset test done");
    summarize();
  end
endmodule
`default_nettype wire
